// *** smsr_cmd_asm.sv ***
// Command word assembly from 16-bit or paired 8-bit host writes
`timescale 1ns/1ps
module smsr_cmd_asm
  import smsr_pkg::*;
(
  // Clock, reset and clock enable
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  // Host command writes
  input  wire logic        word_wr_i,
  input  wire logic [15:0] word_i,
  input  wire logic        byte_wr_i,
  input  wire logic        byte_hi_i,
  input  wire logic [7:0]  byte_i,
  // Assembled command
  output logic             cmd_valid_o,
  output logic [15:0]      cmd_code_o
);
  typedef enum logic [0:0] {
    ASM_IDLE     = 1'b0,
    ASM_LOW_HELD = 1'b1
  } smsr_asm_st_t;

  typedef struct packed {
    smsr_asm_st_t st;
    logic [7:0]   low_byte;
    logic         valid;
    logic [15:0]  code;
  } smsr_asm_t;

  smsr_asm_t r;
  smsr_asm_t next_r;

  always_comb begin
    next_r = r;
    next_r.valid = 1'b0;
    if (word_wr_i) begin
      next_r.valid = 1'b1;
      next_r.code  = word_i;
      next_r.st    = ASM_IDLE;
    end else if (byte_wr_i) begin
      case (r.st)
        ASM_IDLE: begin
          // A lone high byte is dropped: nothing to pair it with
          if (!byte_hi_i) begin
            next_r.low_byte = byte_i;
            next_r.st       = ASM_LOW_HELD;
          end
        end
        ASM_LOW_HELD: begin
          if (byte_hi_i) begin
            next_r.valid = 1'b1;
            next_r.code  = {byte_i, r.low_byte};
            next_r.st    = ASM_IDLE;
          end else begin
            next_r.low_byte = byte_i;
          end
        end
        default: next_r.st = ASM_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      r <= '{st: ASM_IDLE, low_byte: 8'h00, valid: 1'b0, code: 16'h0000};
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  assign cmd_valid_o = r.valid;
  assign cmd_code_o  = r.code;
endmodule

// *** smsr_host_model.sv ***
// Host CPU model issuing command writes over the parallel bus
`timescale 1ns/1ps
module smsr_host_model (
  // Clock
  input  wire logic        ref_clk_i,
  // Command write strobes
  output logic             cmd_word_wr_o,
  output logic [15:0]      cmd_word_o,
  output logic             cmd_byte_wr_o,
  output logic             cmd_byte_hi_o,
  output logic [7:0]       cmd_byte_o
);
  initial begin
    cmd_word_wr_o = 1'b0;
    cmd_word_o    = 16'h0000;
    cmd_byte_wr_o = 1'b0;
    cmd_byte_hi_o = 1'b0;
    cmd_byte_o    = 8'h00;
  end

  task automatic edge1;
    @(posedge ref_clk_i);
    #1;
  endtask

  // Released data shows the inverse, so a stale value never looks valid
  task automatic put_word(input logic [15:0] code);
    cmd_word_wr_o = 1'b1;
    cmd_word_o    = code;
    edge1;
    cmd_word_wr_o = 1'b0;
    cmd_word_o    = ~code;
    edge1;
  endtask

  task automatic put_bytes(input logic [15:0] code);
    cmd_byte_wr_o = 1'b1;
    cmd_byte_hi_o = 1'b0;
    cmd_byte_o    = code[7:0];
    edge1;
    cmd_byte_hi_o = 1'b1;
    cmd_byte_o    = code[15:8];
    edge1;
    cmd_byte_wr_o = 1'b0;
    cmd_byte_o    = ~code[15:8];
    edge1;
  endtask
endmodule

// *** smsr_pkg.sv ***
// Constants for the serial master status reporting block
package smsr_pkg;
  // Status word bit positions
  localparam int ST_DATA_ERR  = 4;
  localparam int ST_REMOTE    = 5;
  localparam int ST_ACCESS    = 6;
  localparam int ST_RX_PEND   = 10;
  localparam int ST_UNDEF     = 11;
  localparam int ST_CYCLIC    = 12;
  localparam int ST_RESET     = 13;
  localparam int ST_COMM      = 14;
  localparam int ST_BREAK     = 15;
  // Interrupt status fields
  localparam int IS_NODE_LO   = 0;
  localparam int IS_NODE_HI   = 5;
  localparam int IS_UNDEF     = 6;
  localparam int IS_NO_RESP   = 7;
  localparam int IS_REM_LO    = 8;
  localparam int IS_REM_HI    = 11;
  localparam int IS_ACC_LO    = 12;
  localparam int IS_ACC_HI    = 15;
  // Reset values
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] ISTAT_RST  = 16'h0000;
  // Commands
  localparam logic [15:0] CMD_BREAK      = 16'h0610;
  localparam logic [7:0]  CMD_CLR_HI     = 8'h04;
  localparam logic [15:0] CMD_CYCLIC_GO  = 16'h3000;
  localparam logic [15:0] CMD_DATA_SEND  = 16'h2000;
  localparam logic [3:0]  CMD_SYS_NIBBLE = 4'h1;
  // Clear command bit positions
  localparam int CLR_DATA_ERR = 4;
  localparam int CLR_REMOTE   = 5;
  localparam int CLR_ACCESS   = 6;
  // Remote reception error codes
  localparam logic [3:0] REM_PORT_MISMATCH = 4'h1;
  localparam logic [3:0] REM_DATA_TO_IO    = 4'h2;
  localparam logic [3:0] REM_RX_OVERFLOW   = 4'h3;
  // Host access error codes
  localparam logic [3:0] ACC_ZERO_NODES = 4'h1;
  localparam logic [3:0] ACC_TX_EMPTY   = 4'h2;
  localparam logic [3:0] ACC_WHILE_BUSY = 4'h3;
  localparam logic [3:0] ACC_UNUSED_NODE = 4'h4;
endpackage

// *** smsr_top.sv ***
// Status and interrupt status reporting of the serial network master
`timescale 1ns/1ps
// Overview of operation
// - Bit 10 set while receive FIFO holds data
// - Bit 12 set when cyclic communication starts
// - Bit 13 high while reset in progress
// - Bit 14 high during system or data communication
// - Bit 15 high during manual break, else zero
// - Failing node number recorded on error, retained
// - Only most recent failing node is reported
// - Interrupt bit 7 records no-response on data error
// - Remote error code stored in bits 8-11
// - Packet mismatch also raises remote reception error
// - Host access error code stored in bits 12-15
// - FIFO access or start while busy gives 0011
// - Status bit 4 and interrupt rise together
// - Group clear ignored when clear enable zero
module smsr_top
  import smsr_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  // Host command writes
  input  wire logic        cmd_word_wr_i,
  input  wire logic [15:0] cmd_word_i,
  input  wire logic        cmd_byte_wr_i,
  input  wire logic        cmd_byte_hi_i,
  input  wire logic [7:0]  cmd_byte_i,
  // Host FIFO access strobe and configuration
  input  wire logic        fifo_access_i,
  input  wire logic        manual_break_cfg_i,
  input  wire logic        clear_enable_cfg_i,
  input  wire logic [6:0]  node_count_i,
  input  wire logic        tx_fifo_empty_i,
  input  wire logic        unused_node_access_i,
  // Engine state
  input  wire logic        rx_fifo_has_data_i,
  input  wire logic        cyclic_started_i,
  input  wire logic        cyclic_stopped_i,
  input  wire logic        reset_active_i,
  input  wire logic        comm_active_i,
  input  wire logic        break_done_i,
  // Engine error events
  input  wire logic        data_comm_error_i,
  input  wire logic        no_response_i,
  input  wire logic        remote_rx_error_i,
  input  wire logic [3:0]  remote_error_code_i,
  input  wire logic [5:0]  error_node_i,
  // Register and command outputs
  output logic [15:0]      main_status_word_o,
  output logic [15:0]      interrupt_error_detail_o,
  output logic             int_o,
  output logic             cmd_valid_o,
  output logic [15:0]      cmd_code_o
);
  typedef struct packed {
    logic [15:0] stat;
    logic [15:0] istat;
    logic        irq;
  } smsr_state_t;

  smsr_state_t r;
  smsr_state_t next_r;
  logic        cmd_valid;
  logic [15:0] cmd_code;
  logic        acc_err;
  logic [3:0]  acc_code;

  // Commands that launch communication on the link
  function automatic logic is_comm_start(input logic [15:0] c);
    return (c[15:12] == CMD_SYS_NIBBLE) || (c == CMD_DATA_SEND) || (c == CMD_CYCLIC_GO);
  endfunction

  smsr_cmd_asm u_cmd_asm (
    .ref_clk_i   (ref_clk_i),
    .reset_i     (reset_i),
    .ce_i        (ce_i),
    .word_wr_i   (cmd_word_wr_i),
    .word_i      (cmd_word_i),
    .byte_wr_i   (cmd_byte_wr_i),
    .byte_hi_i   (cmd_byte_hi_i),
    .byte_i      (cmd_byte_i),
    .cmd_valid_o (cmd_valid),
    .cmd_code_o  (cmd_code)
  );

  // Busy check first: a start while busy is refused whatever else is wrong
  always_comb begin
    acc_err  = 1'b1;
    acc_code = ACC_WHILE_BUSY;
    if (r.stat[ST_COMM] && (fifo_access_i || (cmd_valid && is_comm_start(cmd_code)))) begin
      acc_code = ACC_WHILE_BUSY;
    end else if (cmd_valid && cmd_code == CMD_CYCLIC_GO && node_count_i == 7'h00) begin
      acc_code = ACC_ZERO_NODES;
    end else if (cmd_valid && cmd_code == CMD_DATA_SEND && tx_fifo_empty_i) begin
      acc_code = ACC_TX_EMPTY;
    end else if (unused_node_access_i) begin
      acc_code = ACC_UNUSED_NODE;
    end else begin
      acc_err = 1'b0;
    end
  end

  always_comb begin
    next_r = r;
    next_r.stat[ST_RX_PEND] = rx_fifo_has_data_i;
    next_r.stat[ST_RESET]   = reset_active_i;
    next_r.stat[ST_COMM]    = comm_active_i;
    next_r.stat[ST_UNDEF]   = 1'b0;
    next_r.istat[IS_UNDEF]  = 1'b0;
    if (cyclic_stopped_i) begin
      next_r.stat[ST_CYCLIC] = 1'b0;
    end
    if (cyclic_started_i) begin
      next_r.stat[ST_CYCLIC] = 1'b1;
    end
    // Break flag only lives while manual break mode is selected
    if (!manual_break_cfg_i || break_done_i) begin
      next_r.stat[ST_BREAK] = 1'b0;
    end else if (cmd_valid && cmd_code == CMD_BREAK) begin
      next_r.stat[ST_BREAK] = 1'b1;
    end
    // Group clear first so a same-cycle event still sets its flag
    if (cmd_valid && cmd_code[15:8] == CMD_CLR_HI && clear_enable_cfg_i) begin
      if (cmd_code[CLR_DATA_ERR]) next_r.stat[ST_DATA_ERR] = 1'b0;
      if (cmd_code[CLR_REMOTE])   next_r.stat[ST_REMOTE]   = 1'b0;
      if (cmd_code[CLR_ACCESS])   next_r.stat[ST_ACCESS]   = 1'b0;
    end
    if (data_comm_error_i) begin
      next_r.stat[ST_DATA_ERR] = 1'b1;
      next_r.istat[IS_NO_RESP] = no_response_i;
    end
    // Mismatch reported by a node arrives as a remote error with its code
    if (remote_rx_error_i) begin
      next_r.stat[ST_REMOTE] = 1'b1;
      next_r.istat[IS_REM_HI:IS_REM_LO] = remote_error_code_i;
    end
    if (data_comm_error_i || remote_rx_error_i) begin
      next_r.istat[IS_NODE_HI:IS_NODE_LO] = error_node_i;
    end
    if (acc_err) begin
      next_r.stat[ST_ACCESS] = 1'b1;
      next_r.istat[IS_ACC_HI:IS_ACC_LO] = acc_code;
    end
    next_r.irq = next_r.stat[ST_DATA_ERR] | next_r.stat[ST_REMOTE] | next_r.stat[ST_ACCESS];
  end

  // Words are loaded from engine state and from host commands and access strobes
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      r <= '{stat: STATUS_RST, istat: ISTAT_RST, irq: 1'b0};
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  assign main_status_word_o       = r.stat;
  assign interrupt_error_detail_o = r.istat;
  assign int_o                    = r.irq;
  assign cmd_valid_o              = cmd_valid;
  assign cmd_code_o               = cmd_code;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  rx_pend_follows_a: assert property (ce_i |=> main_status_word_o[ST_RX_PEND] == $past(rx_fifo_has_data_i))
    else $error("rx pending bit does not follow receive FIFO");
  cyclic_start_a: assert property (ce_i && cyclic_started_i |=> main_status_word_o[ST_CYCLIC])
    else $error("cyclic running bit not set on start");
  cyclic_stop_a: assert property (ce_i && cyclic_stopped_i && !cyclic_started_i
    |=> !main_status_word_o[ST_CYCLIC])
    else $error("cyclic running bit not cleared on stop");
  reset_busy_a: assert property (ce_i |=> main_status_word_o[ST_RESET] == $past(reset_active_i))
    else $error("reset busy bit does not follow engine");
  comm_busy_a: assert property (ce_i |=> main_status_word_o[ST_COMM] == $past(comm_active_i))
    else $error("comm busy bit does not follow engine");
  break_zero_a: assert property (ce_i && !manual_break_cfg_i |=> !main_status_word_o[ST_BREAK])
    else $error("break bit set without manual break mode");
  break_set_a: assert property (ce_i && manual_break_cfg_i && !break_done_i
    && cmd_valid_o && cmd_code_o == CMD_BREAK |=> main_status_word_o[ST_BREAK])
    else $error("break busy bit not set by break command");
  node_record_a: assert property (ce_i && (data_comm_error_i || remote_rx_error_i)
    |=> interrupt_error_detail_o[IS_NODE_HI:IS_NODE_LO] == $past(error_node_i))
    else $error("failing node number not recorded");
  // Recorded fields keep their value until the next error
  node_hold_a: assert property (ce_i && !data_comm_error_i && !remote_rx_error_i
    |=> interrupt_error_detail_o[IS_NODE_HI:IS_NODE_LO] == $past(interrupt_error_detail_o[IS_NODE_HI:IS_NODE_LO]))
    else $error("failing node number changed without an error");
  no_resp_a: assert property (ce_i && data_comm_error_i
    |=> interrupt_error_detail_o[IS_NO_RESP] == $past(no_response_i))
    else $error("no-response bit wrong after data error");
  no_resp_hold_a: assert property (ce_i && !data_comm_error_i
    |=> interrupt_error_detail_o[IS_NO_RESP] == $past(interrupt_error_detail_o[IS_NO_RESP]))
    else $error("no-response bit changed without a data error");
  remote_code_a: assert property (ce_i && remote_rx_error_i
    |=> interrupt_error_detail_o[IS_REM_HI:IS_REM_LO] == $past(remote_error_code_i) && main_status_word_o[ST_REMOTE])
    else $error("remote error code not stored");
  remote_hold_a: assert property (ce_i && !remote_rx_error_i
    |=> interrupt_error_detail_o[IS_REM_HI:IS_REM_LO] == $past(interrupt_error_detail_o[IS_REM_HI:IS_REM_LO]))
    else $error("remote error code changed without a remote error");
  zero_nodes_a: assert property (ce_i && !main_status_word_o[ST_COMM] && cmd_valid_o
    && cmd_code_o == CMD_CYCLIC_GO && node_count_i == 7'h00
    |=> interrupt_error_detail_o[IS_ACC_HI:IS_ACC_LO] == ACC_ZERO_NODES && main_status_word_o[ST_ACCESS])
    else $error("zero node count start not flagged");
  busy_access_a: assert property (ce_i && main_status_word_o[ST_COMM] && fifo_access_i
    |=> interrupt_error_detail_o[IS_ACC_HI:IS_ACC_LO] == ACC_WHILE_BUSY)
    else $error("busy access code not stored");
  busy_start_a: assert property (ce_i && main_status_word_o[ST_COMM] && cmd_valid_o
    && is_comm_start(cmd_code_o) |=> interrupt_error_detail_o[IS_ACC_HI:IS_ACC_LO] == ACC_WHILE_BUSY)
    else $error("start while busy not flagged");
  irq_with_err_a: assert property (ce_i && data_comm_error_i |=> main_status_word_o[ST_DATA_ERR] && int_o)
    else $error("interrupt not raised with data error bit");
  clear_blocked_a: assert property (ce_i && !clear_enable_cfg_i && main_status_word_o[ST_DATA_ERR]
    |=> main_status_word_o[ST_DATA_ERR])
    else $error("data error bit cleared while clear disabled");
  undef_zero_a: assert property (!main_status_word_o[ST_UNDEF] && !interrupt_error_detail_o[IS_UNDEF])
    else $error("undefined bit reads one");
endmodule

// *** tb_top.sv ***
// Self-checking testbench for the status reporting block
`timescale 1ns/1ps
module tb_top;
  import smsr_pkg::*;
  logic ref_clk_i, reset_i, ce, fifo_acc, brk_cfg, clr_cfg, tx_empty, unused_acc;
  logic rx_data, cyc_go, cyc_stop, rst_act, comm_act, brk_done, derr, no_resp, rerr;
  logic [6:0]  nodes;
  logic [3:0]  rcode;
  logic [5:0]  enode;
  logic        w_wr, b_wr, b_hi, int_w, cvalid;
  logic [15:0] w_dat, st, det, ccode;
  logic [7:0]  b_dat;
  int          err_total, num_checks;
  int          n_cmds = 0;

  smsr_host_model host (.ref_clk_i(ref_clk_i), .cmd_word_wr_o(w_wr), .cmd_word_o(w_dat),
    .cmd_byte_wr_o(b_wr), .cmd_byte_hi_o(b_hi), .cmd_byte_o(b_dat));

  smsr_top dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .ce_i(ce), .cmd_word_wr_i(w_wr),
    .cmd_word_i(w_dat), .cmd_byte_wr_i(b_wr), .cmd_byte_hi_i(b_hi), .cmd_byte_i(b_dat),
    .fifo_access_i(fifo_acc), .manual_break_cfg_i(brk_cfg), .clear_enable_cfg_i(clr_cfg),
    .node_count_i(nodes), .tx_fifo_empty_i(tx_empty), .unused_node_access_i(unused_acc),
    .rx_fifo_has_data_i(rx_data), .cyclic_started_i(cyc_go), .cyclic_stopped_i(cyc_stop),
    .reset_active_i(rst_act), .comm_active_i(comm_act), .break_done_i(brk_done),
    .data_comm_error_i(derr), .no_response_i(no_resp), .remote_rx_error_i(rerr),
    .remote_error_code_i(rcode), .error_node_i(enode), .main_status_word_o(st),
    .interrupt_error_detail_o(det), .int_o(int_w), .cmd_valid_o(cvalid), .cmd_code_o(ccode));

  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  // One count per assembled-command pulse
  always @(posedge ref_clk_i) begin
    if (cvalid === 1'b1) n_cmds++;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // One-cycle error event from the engine
  task automatic err_evt(input logic is_data, input logic nr, input logic [5:0] nd, input logic [3:0] c);
    derr = is_data;
    rerr = !is_data;
    no_resp = nr;
    enode = nd;
    rcode = c;
    tick(1);
    derr = 1'b0;
    rerr = 1'b0;
    // Lets an edge pass so the next event never rewrites these in the same step
    tick(1);
  endtask

  task automatic t_freeze;
    ce = 1'b0;
    rx_data = 1'b1;
    tick(2);
    chk("frozen status", 16'h0000, st & 16'h0400);
    ce = 1'b1;
    tick(1);
    chk("status after thaw", 16'h0400, st & 16'h0400);
    rx_data = 1'b0;
    tick(1);
    chk("rx pending cleared", 16'h0000, st & 16'h0400);
    $display("test freeze done");
  endtask

  task automatic t_levels;
    rx_data = 1'b1;
    rst_act = 1'b1;
    comm_act = 1'b1;
    cyc_go = 1'b1;
    tick(1);
    cyc_go = 1'b0;
    chk("status busy bits", 16'h7400, st & 16'hFC00);
    rx_data = 1'b0;
    rst_act = 1'b0;
    comm_act = 1'b0;
    tick(1);
    chk("status idle bits", 16'h1000, st & 16'hFC00);
    cyc_stop = 1'b1;
    tick(1);
    cyc_stop = 1'b0;
    chk("cyclic bit cleared", 16'h0000, st & 16'h1000);
    $display("test levels done");
  endtask

  task automatic t_errors;
    err_evt(1'b1, 1'b1, 6'h05, 4'h0);
    chk("data error status", 16'h0010, st & 16'h0070);
    chk("interrupt line", 16'h0001, {15'h0000, int_w});
    chk("detail node and no-response", 16'h0085, det & 16'h00FF);
    for (int c = 1; c <= 3; c++) begin
      err_evt(1'b0, 1'b0, 6'(8 + c), 4'(c));
      chk("remote code and node", {4'h0, 4'(c), 8'h80} | 16'(8 + c), det & 16'h0FFF);
    end
    chk("remote error status", 16'h0030, st & 16'h0070);
    err_evt(1'b1, 1'b0, 6'h3F, 4'h0);
    chk("latest node, response seen", 16'h033F, det & 16'h0FFF);
    $display("test errors done");
  endtask

  task automatic t_access;
    nodes = 7'h00;
    host.put_word(CMD_CYCLIC_GO);
    chk("zero nodes code", 16'h1000, det & 16'hF000);
    nodes = 7'h04;
    tx_empty = 1'b1;
    host.put_word(CMD_DATA_SEND);
    chk("empty fifo code", 16'h2000, det & 16'hF000);
    unused_acc = 1'b1;
    tick(1);
    unused_acc = 1'b0;
    chk("unused node code", 16'h4000, det & 16'hF000);
    comm_act = 1'b1;
    tick(1);
    host.put_word(CMD_DATA_SEND);
    chk("busy start code", 16'h3000, det & 16'hF000);
    unused_acc = 1'b1;
    tick(1);
    unused_acc = 1'b0;
    chk("unused node code while busy", 16'h4000, det & 16'hF000);
    fifo_acc = 1'b1;
    tick(1);
    fifo_acc = 1'b0;
    chk("busy fifo code", 16'h3000, det & 16'hF000);
    comm_act = 1'b0;
    chk("access error status", 16'h0070, st & 16'h0070);
    host.put_word(16'h0470);
    chk("clear refused", 16'h0070, st & 16'h0070);
    clr_cfg = 1'b1;
    host.put_word(16'h0470);
    chk("clear taken", 16'h0000, st & 16'h0070);
    chk("interrupt released", 16'h0000, {15'h0000, int_w});
    $display("test access done");
  endtask

  task automatic t_break;
    brk_cfg = 1'b1;
    host.put_bytes(CMD_BREAK);
    chk("assembled code", CMD_BREAK, ccode);
    chk("break busy", 16'h8000, st & 16'h8000);
    brk_done = 1'b1;
    tick(1);
    brk_done = 1'b0;
    chk("break finished", 16'h0000, st & 16'h8000);
    brk_cfg = 1'b0;
    host.put_bytes(CMD_BREAK);
    chk("break ignored", 16'h0000, st & 16'h8000);
    chk("command pulses", 16'h0007, 16'(n_cmds));
    $display("test break done");
  endtask

  initial begin
    #200000;
    err_total++;
    give_verdict;
  end

  initial begin
    {reset_i, fifo_acc, brk_cfg, clr_cfg, tx_empty, unused_acc} = 6'b100000;
    ce = 1'b1;
    {rx_data, cyc_go, cyc_stop, rst_act, comm_act, brk_done, derr, no_resp, rerr} = 9'h000;
    nodes = 7'h04;
    rcode = 4'h0;
    enode = 6'h00;
    err_total = 0;
    num_checks = 0;
    tick(20);
    reset_i = 1'b0;
    chk("status after reset", STATUS_RST, st);
    chk("detail after reset", ISTAT_RST, det);
    t_freeze;
    t_levels;
    t_errors;
    t_access;
    t_break;
    give_verdict;
  end
endmodule
